// File: swr_defs.svh
`ifndef SWR_DEFS_SVH
`define SWR_DEFS_SVH

// Sleep mode indices
`define SWR_MODE_IDLE      3'h0
`define SWR_MODE_FROZEN    3'h1
`define SWR_MODE_STANDBY   3'h2
`define SWR_MODE_STOP      3'h3
`define SWR_MODE_DEEPSTOP  3'h4
`define SWR_MODE_STATIC    3'h5

// Reset cause bit positions
`define SWR_RC_POR         0
`define SWR_RC_EXT         1
`define SWR_RC_BOD         2
`define SWR_RC_WDT         3
`define SWR_RC_OCD         4
`define SWR_RC_W           5

// Reset values
`define SWR_PERIPHERAL_POWER_CONTROL_RST       8'hff
`define SWR_ASYNC_WAKE_ENABLE_RST       8'h00

// Source ready timeout, ns; cycles at 100 ns per cycle
`define SWR_RDY_TMO_NS     3200
`define SWR_CLK_NS         100
`define SWR_RDY_TMO_CYC    (`SWR_RDY_TMO_NS / `SWR_CLK_NS)

`endif

// File: swr_pkg.sv
package swr_pkg;
    typedef enum logic [2:0] {
        SWR_RUN,
        SWR_HALT,
        SWR_SLEEP,
        SWR_WALK,
        SWR_START,
        SWR_WAKE
    } swr_state_t;
endpackage : swr_pkg

// File: swr_clk_plan.sv
`include "swr_defs.svh"

module swr_clk_plan
    import swr_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    input  wire logic       clk_en,
    input  wire logic       load,
    input  wire logic [2:0] mode,
    input  wire logic       slow_osc_en,
    output logic            cpu_run_ff,
    output logic            hsb_run_ff,
    output logic            pb_run_ff,
    output logic            src_run_ff,
    output logic            slow_osc_run_ff,
    output logic            rc_run_ff,
    output logic            bod_on_ff,
    output logic            lp_reg_ff,
    output logic            sync_wake_ok_ff,
    output logic            pb_only_wake_ff,
    output logic            wdt_wake_ok_ff
);
    // Mode decode into run masks
    wire logic idle_ok  = (mode == `SWR_MODE_IDLE);
    wire logic pb_ok    = (mode <= `SWR_MODE_FROZEN);
    wire logic src_ok   = (mode <= `SWR_MODE_STANDBY);
    wire logic bod_ok   = (mode <= `SWR_MODE_STOP);
    wire logic rc_ok    = (mode <= `SWR_MODE_DEEPSTOP);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_run_ff      <= 1'b1;
            hsb_run_ff      <= 1'b1;
            pb_run_ff       <= 1'b1;
            src_run_ff      <= 1'b1;
            slow_osc_run_ff <= 1'b0;
            rc_run_ff       <= 1'b1;
            bod_on_ff       <= 1'b1;
            lp_reg_ff       <= 1'b0;
            sync_wake_ok_ff <= 1'b1;
            pb_only_wake_ff <= 1'b0;
            wdt_wake_ok_ff  <= 1'b1;
        end else if (clk_en && load) begin
            cpu_run_ff      <= 1'b0;
            hsb_run_ff      <= idle_ok;
            pb_run_ff       <= pb_ok;
            src_run_ff      <= src_ok;
            slow_osc_run_ff <= slow_osc_en;
            rc_run_ff       <= rc_ok;
            bod_on_ff       <= bod_ok;
            lp_reg_ff       <= !src_ok;
            sync_wake_ok_ff <= pb_ok;
            pb_only_wake_ff <= (mode == `SWR_MODE_FROZEN);
            wdt_wake_ok_ff  <= rc_ok || slow_osc_en;
        end
    end
endmodule : swr_clk_plan

// File: swr_ctrl.sv
// Operation
// - Idle stops only the CPU clock
// - Frozen also stops high speed bus
// - Standby stops all synchronous clocks, sources run
// - Stop halts sources and count-compare clock
// - DeepStop turns off bandgap and brown-out
// - Static stops system RC too
// - Regulator low power for modes three-five
// - Slow oscillator runs only if pre-enabled
// - Sleep request carries the mode index
// - Unmasked interrupts are synchronous wake sources
// - Timer, watchdog, pins, reset, enabled asynchronous wake
// - Modes zero-one wake sync; others async only
// - Static watchdog wake needs pre-enabled slow oscillator
// - Clock request starts only that clock
// - Async wake keeps requested clock running
// - Clock requests maskable, all enabled at reset
// - Interrupt clock runs; pending interrupt wakes fully
// - CPU halted after bus operations finish
// - Divided clocks maskable, stop with peripheral clocks
// - Five reset sources; only power-on resets all
// - Latest reset source kept readable
// - Low external reset pin asserts reset
`include "swr_defs.svh"

module swr_ctrl
    import swr_pkg::*;
#(
    parameter int NPB  = 8,
    parameter int NDIV = 8
) (
    input  wire logic            ref_clk,
    input  wire logic            arst_n,
    input  wire logic            clk_en,
    input  wire logic            sleep_req,
    input  wire logic [2:0]      sleep_mode,
    input  wire logic            cpu_bus_idle,
    input  wire logic            cpu_safe_ack,
    input  wire logic            irq_pending,
    input  wire logic            irq_pb_source,
    input  wire logic            async_timer_wake,
    input  wire logic            watchdog_wake,
    input  wire logic            ext_irq_wake,
    input  wire logic [7:0]      async_wake_src,
    input  wire logic [7:0]      async_wake_enable,
    input  wire logic [NPB-1:0]  pb_clk_req,
    input  wire logic [NPB-1:0]  peripheral_power_control,
    input  wire logic            peripheral_power_load,
    input  wire logic [NDIV-1:0] div_mask,
    input  wire logic            slow_osc_enabled,
    input  wire logic            src_ready,
    input  wire logic            por_rst,
    input  wire logic            ext_reset_n,
    input  wire logic            bod_rst,
    input  wire logic            wdt_rst,
    input  wire logic            ocd_rst,
    output logic                 cpu_halt_ff,
    output logic                 cpu_clk_en_ff,
    output logic                 hsb_clk_en_ff,
    output logic [NPB-1:0]       pb_clk_en_ff,
    output logic [NDIV-1:0]      div_clk_en_ff,
    output logic                 intc_clk_en_ff,
    output logic                 src_en_ff,
    output logic                 slow_osc_en_ff,
    output logic                 rc_en_ff,
    output logic                 bod_en_ff,
    output logic                 low_power_reg_ff,
    output logic                 sleeping_ff,
    output logic                 walking_ff,
    output logic                 hard_reset_ff,
    output logic                 soft_reset_ff,
    output logic [5:0]           reset_cause_ff,
    output logic [NPB-1:0]       ppc_ff,
    output logic                 timeout_ff
);
    ////////////////////////////////////////////////////////////////////////////////
    swr_state_t     st_ff;
    swr_state_t     nxt_st;
    logic [2:0]     mode_ff;
    logic [NPB-1:0] walk_req_ff;
    logic [NPB-1:0] nxt_walk_req;
    logic [7:0]     tmo_ff;
    logic [7:0]     nxt_tmo;
    logic           plan_load;

    wire logic cpu_run, hsb_run, pb_run, src_run, slow_run, rc_run, bod_on, lp_reg;
    wire logic sync_ok, pb_only, wdt_ok;

    swr_clk_plan u_plan (
        .ref_clk         (ref_clk),
        .arst_n          (arst_n),
        .clk_en          (clk_en),
        .load            (plan_load),
        .mode            (mode_ff),
        .slow_osc_en     (slow_osc_enabled),
        .cpu_run_ff      (cpu_run),
        .hsb_run_ff      (hsb_run),
        .pb_run_ff       (pb_run),
        .src_run_ff      (src_run),
        .slow_osc_run_ff (slow_run),
        .rc_run_ff       (rc_run),
        .bod_on_ff       (bod_on),
        .lp_reg_ff       (lp_reg),
        .sync_wake_ok_ff (sync_ok),
        .pb_only_wake_ff (pb_only),
        .wdt_wake_ok_ff  (wdt_ok)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Wake decode
    wire logic sync_wake  = irq_pending && sync_ok && (!pb_only || irq_pb_source);
    wire logic async_wake = async_timer_wake || (watchdog_wake && wdt_ok)
                          || ext_irq_wake || (|(async_wake_src & async_wake_enable));
    wire logic any_wake   = sync_wake || async_wake;
    wire logic [NPB-1:0] req_ok = pb_clk_req & ppc_ff;
    wire logic walk_start = !pb_run && (|req_ok);
    wire logic ext_rst    = !ext_reset_n;
    wire logic any_rst    = por_rst || ext_rst || bod_rst || wdt_rst || ocd_rst;
    wire logic tmo_hit    = (tmo_ff == 8'(`SWR_RDY_TMO_CYC));
    wire logic asleep     = (st_ff == SWR_SLEEP) || (st_ff == SWR_WALK);
    assign plan_load = (st_ff == SWR_HALT) && cpu_safe_ack;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st       = st_ff;
        nxt_walk_req = walk_req_ff;
        nxt_tmo      = 8'h00;
        case (st_ff)
            SWR_RUN: begin
                if (sleep_req && cpu_bus_idle) begin
                    nxt_st = SWR_HALT;
                end
            end
            SWR_HALT: begin
                if (cpu_safe_ack) begin
                    nxt_st = SWR_SLEEP;
                end
            end
            SWR_SLEEP: begin
                if (any_wake || ext_rst) begin
                    nxt_st = SWR_START;
                end else if (walk_start) begin
                    nxt_st       = SWR_WALK;
                    nxt_walk_req = req_ok;
                end
            end
            SWR_WALK: begin
                nxt_walk_req = walk_req_ff | req_ok;
                if (any_wake || irq_pending) begin
                    nxt_st = SWR_START;
                end else if (!(|req_ok)) begin
                    nxt_st       = SWR_SLEEP;
                    nxt_walk_req = '0;
                end
            end
            SWR_START: begin
                nxt_tmo = tmo_ff + 8'h01;
                if (src_ready || tmo_hit) begin
                    nxt_st = SWR_WAKE;
                end
            end
            SWR_WAKE: begin
                nxt_st       = SWR_RUN;
                nxt_walk_req = '0;
            end
            default: begin
                nxt_st = SWR_RUN;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_ff       <= SWR_RUN;
            mode_ff     <= `SWR_MODE_IDLE;
            walk_req_ff <= '0;
            tmo_ff      <= 8'h00;
        end else if (clk_en) begin
            st_ff       <= nxt_st;
            walk_req_ff <= nxt_walk_req;
            tmo_ff      <= nxt_tmo;
            if (st_ff == SWR_RUN && sleep_req) begin
                mode_ff <= (sleep_mode > `SWR_MODE_STATIC) ? `SWR_MODE_STATIC : sleep_mode;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Clock outputs; a requested peripheral clock survives the wake ramp
    wire logic awake    = (st_ff == SWR_RUN) || (st_ff == SWR_HALT);
    wire logic ramp     = (st_ff == SWR_START);
    wire logic walk_src = (st_ff == SWR_WALK) || (ramp && (|walk_req_ff));
    wire logic pb_full  = awake || (asleep && pb_run);
    wire logic [NPB-1:0] nxt_pb = pb_full ? '1 : walk_req_ff;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_halt_ff      <= 1'b0;
            cpu_clk_en_ff    <= 1'b1;
            hsb_clk_en_ff    <= 1'b1;
            pb_clk_en_ff     <= '1;
            div_clk_en_ff    <= '1;
            intc_clk_en_ff   <= 1'b1;
            src_en_ff        <= 1'b1;
            slow_osc_en_ff   <= 1'b0;
            rc_en_ff         <= 1'b1;
            bod_en_ff        <= 1'b1;
            low_power_reg_ff <= 1'b0;
            sleeping_ff      <= 1'b0;
            walking_ff       <= 1'b0;
        end else if (clk_en) begin
            cpu_halt_ff      <= (st_ff == SWR_HALT) || asleep || ramp;
            cpu_clk_en_ff    <= awake;
            hsb_clk_en_ff    <= awake || (asleep && hsb_run);
            pb_clk_en_ff     <= nxt_pb;
            div_clk_en_ff    <= pb_full ? div_mask : '0;
            intc_clk_en_ff   <= !asleep || pb_run || (st_ff == SWR_WALK);
            src_en_ff        <= !asleep || src_run || walk_src || ramp;
            slow_osc_en_ff   <= slow_osc_enabled && (!asleep || slow_run);
            rc_en_ff         <= !asleep || rc_run || walk_src;
            bod_en_ff        <= !asleep || bod_on;
            low_power_reg_ff <= asleep && lp_reg;
            sleeping_ff      <= asleep;
            walking_ff       <= (nxt_st == SWR_WALK);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Resets and cause; peripheral power control kept over non power-on resets
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            hard_reset_ff  <= 1'b1;
            soft_reset_ff  <= 1'b1;
            reset_cause_ff <= 6'h01;
            ppc_ff         <= '1;
            timeout_ff     <= 1'b0;
        end else if (clk_en) begin
            hard_reset_ff <= por_rst;
            soft_reset_ff <= any_rst;
            if (any_rst) begin
                reset_cause_ff <= {1'b0, ocd_rst, wdt_rst, bod_rst, ext_rst, por_rst};
            end
            if (por_rst) begin
                ppc_ff <= '1;
            end else if (peripheral_power_load) begin
                ppc_ff <= peripheral_power_control;
            end
            if (ramp && tmo_hit) begin
                timeout_ff <= 1'b1;
            end else if (st_ff == SWR_RUN && sleep_req) begin
                timeout_ff <= 1'b0;
            end
        end
    end
endmodule : swr_ctrl

// File: swr_ctrl_properties.sv
`include "swr_defs.svh"

module swr_ctrl_properties #(
    parameter int NPB  = 8,
    parameter int NDIV = 8
) (
    input wire logic            ref_clk,
    input wire logic            arst_n,
    input wire logic            cpu_bus_idle,
    input wire logic            async_timer_wake,
    input wire logic            watchdog_wake,
    input wire logic            ext_irq_wake,
    input wire logic [7:0]      async_wake_src,
    input wire logic [7:0]      async_wake_enable,
    input wire logic [NPB-1:0]  pb_clk_req,
    input wire logic            src_ready,
    input wire logic            por_rst,
    input wire logic            ext_reset_n,
    input wire logic            cpu_halt_ff,
    input wire logic            cpu_clk_en_ff,
    input wire logic            hsb_clk_en_ff,
    input wire logic [NPB-1:0]  pb_clk_en_ff,
    input wire logic [NDIV-1:0] div_clk_en_ff,
    input wire logic            intc_clk_en_ff,
    input wire logic            src_en_ff,
    input wire logic            bod_en_ff,
    input wire logic            low_power_reg_ff,
    input wire logic            sleeping_ff,
    input wire logic            walking_ff,
    input wire logic            hard_reset_ff,
    input wire logic            soft_reset_ff,
    input wire logic [5:0]      reset_cause_ff,
    input wire logic [NPB-1:0]  ppc_ff,
    input wire logic            timeout_ff
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    logic deep_asleep;
    logic async_quiet;
    assign deep_asleep = sleeping_ff && !walking_ff && pb_clk_en_ff == '0;
    assign async_quiet = !async_timer_wake && !watchdog_wake && !ext_irq_wake && ext_reset_n
                         && (async_wake_src & async_wake_enable) == 8'h00 && pb_clk_req == '0;
    ////////////////////////////////////////
    sequence s_quiet_sleep;
        (deep_asleep && async_quiet) [*2];
    endsequence
    sequence s_held_busy;
        (!cpu_bus_idle && !cpu_halt_ff) [*2];
    endsequence
    ////////////////////////////////////////
    a_halt_gate: assert property ($fell(cpu_clk_en_ff) |-> cpu_halt_ff)
        else $error("clock gated before halt");
    a_busy_no_halt: assert property (s_held_busy |=> !cpu_halt_ff)
        else $error("halt with bus busy");
    a_ready_then_clock: assert property ($rose(cpu_clk_en_ff) |-> src_en_ff && (src_ready || timeout_ff))
        else $error("clock before source ready");
    a_lp_stops_src: assert property ($rose(sleeping_ff) |-> low_power_reg_ff == !src_en_ff)
        else $error("regulator and sources disagree");
    a_bod_low_power: assert property ($rose(sleeping_ff) && !bod_en_ff |-> low_power_reg_ff)
        else $error("bod off outside low power");
    a_domain_order: assert property ($rose(sleeping_ff) |-> !cpu_clk_en_ff
        && (!hsb_clk_en_ff || pb_clk_en_ff != '0) && (pb_clk_en_ff == '0 || src_en_ff))
        else $error("domain plan out of order");
    a_div_with_pb: assert property (deep_asleep |-> div_clk_en_ff == '0)
        else $error("divided clock runs in sleep");
    a_walk_masked: assert property (walking_ff |-> (pb_clk_en_ff & ~ppc_ff) == '0)
        else $error("masked request got a clock");
    a_walk_intc: assert property (walking_ff [*2] |-> intc_clk_en_ff)
        else $error("interrupt clock off in walk");
    a_deep_no_sync: assert property (s_quiet_sleep |=> sleeping_ff)
        else $error("woke without async source");
    a_por_hard: assert property (por_rst |=> hard_reset_ff && reset_cause_ff[`SWR_RC_POR])
        else $error("power-on reset missed");
    a_ext_soft: assert property (!ext_reset_n && !por_rst |=> soft_reset_ff && !hard_reset_ff
        && reset_cause_ff[`SWR_RC_EXT])
        else $error("external reset wrong");
endmodule : swr_ctrl_properties

// File: swr_cpu_model.sv
module swr_cpu_model (
    input  wire logic ref_clk,
    input  wire logic arst_n,
    input  wire logic cpu_halt_ff,
    input  wire logic src_en_ff,
    input  wire logic slow,
    output logic      cpu_safe_ack,
    output logic      src_ready
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] cnt_ff;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_safe_ack <= 1'b0;
            cnt_ff       <= 6'h00;
        end else begin
            cpu_safe_ack <= cpu_halt_ff;
            cnt_ff       <= !src_en_ff ? 6'h00 : (cnt_ff == 6'h3f ? cnt_ff : cnt_ff + 6'h01);
        end
    end
    // Slow start-up outlasts the ready timeout on purpose
    assign src_ready = src_en_ff && (cnt_ff >= (slow ? 6'h28 : 6'h02));
endmodule : swr_cpu_model

// File: testbench.sv
`include "swr_defs.svh"

module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic       ref_clk, arst_n, clk_en, sleep_req, cpu_bus_idle, cpu_safe_ack, src_ready;
    logic       irq_pending, irq_pb_source, async_timer_wake, watchdog_wake, ext_irq_wake;
    logic       peripheral_power_load, slow_osc_enabled, por_rst, ext_reset_n, bod_rst;
    logic       wdt_rst, ocd_rst, slow, cpu_halt_ff, cpu_clk_en_ff, hsb_clk_en_ff, timeout_ff;
    logic       intc_clk_en_ff, src_en_ff, slow_osc_en_ff, rc_en_ff, bod_en_ff, walking_ff;
    logic       low_power_reg_ff, sleeping_ff, hard_reset_ff, soft_reset_ff;
    logic [2:0] sleep_mode;
    logic [3:0] watch;
    logic [4:0] got;
    logic [5:0] reset_cause_ff;
    logic [7:0] async_wake_src, async_wake_enable, pb_clk_req, peripheral_power_control;
    logic [7:0] div_mask, pb_clk_en_ff, div_clk_en_ff, ppc_ff;
    int         checks, miscompares;
    assign watch = {walking_ff, cpu_clk_en_ff, sleeping_ff, cpu_halt_ff};
    swr_ctrl #(.NPB(8), .NDIV(8)) u_dut (.ref_clk, .arst_n, .clk_en, .sleep_req, .sleep_mode,
        .cpu_bus_idle, .cpu_safe_ack, .irq_pending, .irq_pb_source, .async_timer_wake,
        .watchdog_wake, .ext_irq_wake, .async_wake_src, .async_wake_enable, .pb_clk_req,
        .peripheral_power_control, .peripheral_power_load, .div_mask, .slow_osc_enabled,
        .src_ready, .por_rst, .ext_reset_n, .bod_rst, .wdt_rst, .ocd_rst, .cpu_halt_ff,
        .cpu_clk_en_ff, .hsb_clk_en_ff, .pb_clk_en_ff, .div_clk_en_ff, .intc_clk_en_ff,
        .src_en_ff, .slow_osc_en_ff, .rc_en_ff, .bod_en_ff, .low_power_reg_ff, .sleeping_ff,
        .walking_ff, .hard_reset_ff, .soft_reset_ff, .reset_cause_ff, .ppc_ff, .timeout_ff);
    swr_cpu_model u_cpu (.ref_clk, .arst_n, .cpu_halt_ff, .src_en_ff, .slow, .cpu_safe_ack,
        .src_ready);
    always #50 ref_clk = ~ref_clk;
    ////////////////////////////////////////
    task step;
        @(posedge ref_clk);
    endtask : step
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic wait_on(input int b, input int n);
        for (int i = 0; i < n && watch[b] !== 1'b1; i++) begin
            @(negedge ref_clk);
        end
    endtask : wait_on
    task automatic go_sleep(input logic [2:0] m);
        step;
        sleep_mode <= m;
        sleep_req  <= 1'b1;
        wait_on(0, 20);
        step;
        sleep_req <= 1'b0;
        wait_on(1, 20);
        @(negedge ref_clk);
    endtask : go_sleep
    task automatic wake(input int k);
        step;
        case (k)
            0: irq_pending <= 1'b1;
            1: {irq_pending, irq_pb_source} <= 2'h3;
            2: async_timer_wake <= 1'b1;
            3: async_wake_src <= 8'h08;
            4: ext_irq_wake <= 1'b1;
            default: watchdog_wake <= 1'b1;
        endcase
        wait_on(2, 80);
        chk(16'({cpu_clk_en_ff, cpu_halt_ff}), 16'h2);
        step;
        {irq_pending, irq_pb_source, async_timer_wake, ext_irq_wake, watchdog_wake} <= 5'h0;
        async_wake_src <= 8'h00;
    endtask : wake
    ////////////////////////////////////////
    task automatic t_modes;
        for (int m = 0; m < 6; m++) begin
            step;
            slow_osc_enabled <= m[0];
            go_sleep(3'(m));
            got = {cpu_clk_en_ff, hsb_clk_en_ff, |pb_clk_en_ff, |div_clk_en_ff, src_en_ff};
            chk(16'(got), 16'({1'b0, m == 0, m < 2, m < 2, m < 3}));
            got = {1'b0, rc_en_ff, bod_en_ff, low_power_reg_ff, slow_osc_en_ff};
            chk(16'(got), 16'({1'b0, m < 5, m < 4, m > 2, m[0]}));
            wake(m);
        end
        $display("modes done");
    endtask : t_modes
    task automatic t_busy;
        step;
        div_mask     <= 8'h0f;
        cpu_bus_idle <= 1'b0;
        sleep_req    <= 1'b1;
        repeat (6) @(negedge ref_clk);
        chk(16'(div_clk_en_ff), 16'h0f);
        chk(16'(cpu_halt_ff), 16'h0);
        step;
        clk_en       <= 1'b0;
        sleep_mode   <= 3'h0;
        cpu_bus_idle <= 1'b1; // Masters quiet before sleep
        repeat (4) @(negedge ref_clk);
        chk(16'({cpu_halt_ff, sleeping_ff}), 16'h0);
        step;
        clk_en   <= 1'b1;
        div_mask <= 8'hff;
        go_sleep(3'h0);
        chk(16'({hsb_clk_en_ff, sleeping_ff}), 16'h3);
        wake(4);
        $display("busy done");
    endtask : t_busy
    task automatic t_refuse;
        step;
        slow_osc_enabled <= 1'b0;
        go_sleep(3'h7);
        chk(16'({rc_en_ff, src_en_ff}), 16'h0);
        step;
        {irq_pending, watchdog_wake} <= 2'h3;
        async_wake_src <= 8'h01;
        repeat (8) @(negedge ref_clk);
        chk(16'(sleeping_ff), 16'h1);
        wake(4);
        $display("refuse done");
    endtask : t_refuse
    task automatic t_walk;
        step;
        {peripheral_power_control, peripheral_power_load} <= 9'h1e1;
        step;
        peripheral_power_load <= 1'b0;
        go_sleep(3'h3);
        step;
        pb_clk_req <= 8'h11;
        wait_on(3, 20);
        repeat (2) @(negedge ref_clk);
        chk(16'({cpu_clk_en_ff, pb_clk_en_ff}), 16'h0010);
        chk(16'(intc_clk_en_ff), 16'h1);
        wake(4);
        chk(16'({pb_clk_en_ff[4], ppc_ff}), 16'h01f0);
        pb_clk_req <= 8'h00;
        $display("walk done");
    endtask : t_walk
    task automatic t_timeout;
        int n;
        step;
        slow <= 1'b1;
        go_sleep(3'h3);
        step;
        async_timer_wake <= 1'b1;
        for (n = 0; n < 100 && cpu_clk_en_ff !== 1'b1; n++) begin
            @(negedge ref_clk);
        end
        chk(16'({timeout_ff, n >= `SWR_RDY_TMO_CYC}), 16'h3);
        step;
        {async_timer_wake, slow} <= 2'h0;
        $display("timeout done");
    endtask : t_timeout
    task automatic t_reset;
        step;
        por_rst <= 1'b1;
        step;
        por_rst <= 1'b0;
        @(negedge ref_clk);
        chk(16'({hard_reset_ff, reset_cause_ff[0], ppc_ff}), 16'h03ff);
        for (int k = 1; k < 5; k++) begin
            step;
            {ocd_rst, wdt_rst, bod_rst, ext_reset_n} <= 4'(((1 << (k - 1)) & 14) | (k != 1));
            step;
            {ocd_rst, wdt_rst, bod_rst, ext_reset_n} <= 4'h1;
            @(negedge ref_clk);
            chk(16'({hard_reset_ff, soft_reset_ff, reset_cause_ff[k]}), 16'h3);
        end
        $display("reset done");
    endtask : t_reset
    task summarize;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : summarize
    ////////////////////////////////////////
    initial begin
        {ref_clk, arst_n, sleep_req, irq_pending, irq_pb_source, async_timer_wake} = '0;
        {watchdog_wake, ext_irq_wake, peripheral_power_load, slow_osc_enabled, por_rst} = '0;
        {bod_rst, wdt_rst, ocd_rst, slow, sleep_mode, async_wake_src, pb_clk_req} = '0;
        {clk_en, cpu_bus_idle, ext_reset_n, div_mask, peripheral_power_control} = 19'h7ffff;
        async_wake_enable = 8'h08;
        checks = 0;
        miscompares = 0;
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        @(negedge ref_clk);
        chk(16'(ppc_ff), 16'h00ff);
        t_modes;
        t_busy;
        t_refuse;
        t_walk;
        t_timeout;
        t_reset;
        summarize;
    end
    // Whole run needs under four hundred cycles; over twelve times that means a hang
    initial begin
        repeat (5000) @(posedge ref_clk);
        miscompares++;
        summarize;
    end
endmodule : testbench

bind swr_ctrl swr_ctrl_properties #(.NPB(NPB), .NDIV(NDIV)) u_props (.ref_clk, .arst_n,
    .cpu_bus_idle, .async_timer_wake, .watchdog_wake, .ext_irq_wake, .async_wake_src,
    .async_wake_enable, .pb_clk_req, .src_ready, .por_rst, .ext_reset_n, .cpu_halt_ff,
    .cpu_clk_en_ff, .hsb_clk_en_ff, .pb_clk_en_ff, .div_clk_en_ff, .intc_clk_en_ff, .src_en_ff,
    .bod_en_ff, .low_power_reg_ff, .sleeping_ff, .walking_ff, .hard_reset_ff, .soft_reset_ff,
    .reset_cause_ff, .ppc_ff, .timeout_ff);
